/* design/ueps_endpoint.sv */
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ueps_params.svh"

module ueps_endpoint #(
    parameter int MAX_BANKS  = 3,
    parameter int MAX_SZCODE = 7,
    parameter int FIFO_BYTES = 4096,
    parameter int BC_W       = 11
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        usb_bus_reset,
    input  wire logic        sw_byte_wr,
    input  wire logic        sw_byte_rd,
    input  wire logic        usb_byte_rx,
    input  wire logic        usb_byte_tx,
    input  wire logic        usb_in_token,
    input  wire logic        usb_in_done,
    input  wire logic        usb_out_start,
    input  wire logic        usb_out_done,
    input  wire logic [1:0]  usb_out_pid,
    input  wire logic        usb_out_crc_err,
    input  wire logic        usb_setup_rcv,
    input  wire logic        usb_setup_dir_in,
    input  wire logic        usb_nak_in_sent,
    input  wire logic        usb_nak_out_sent,
    input  wire logic        usb_stall_sent,
    input  wire logic        usb_microframe_end,
    output logic             stall_request,
    output logic             send_zlp,
    output logic             out_discard,
    output logic             fifo_flush,
    output logic             rw_allowed,
    output logic             endpoint_irq
);
    localparam int NF = 12;
    localparam int F_INRDY = 0, F_OUTRX = 1, F_SETUP = 2, F_NAKOUT = 3;
    localparam int F_NAKIN = 4, F_OVER = 5, F_STALL = 6, F_SHORT = 7;
    localparam int F_UNDER = 8, F_HBUND = 9, F_FLUSH = 10, F_CRC = 11;

    logic [`UEPS_CFG_W-1:0] cfg_reg;
    logic [`UEPS_MSK_W-1:0] mask_reg;
    logic                   stall_reg;
    logic                   config_valid_reg;
    logic                   control_direction_reg;
    logic [1:0]             toggle_sequence_reg;
    logic [BC_W-1:0]        bcnt_reg [3];
    logic [1:0]             cur_bank_reg;
    logic [1:0]             busy_reg;
    logic [1:0]             rel_pipe_reg;
    logic [NF-1:0]          flag_reg;
    logic                   trerr_reg;
    logic                   fifo_control_d_reg;
    logic [1:0]             mf_tx_reg;
    logic [1:0]             mf_fill_reg;
    logic [1:0]             mf_rx_reg;
    logic                   drop_reg;
    logic [31:0]            rdata_reg;
    logic                   irq_reg;

    ueps_pkg::ueps_type_t ep_type;
    logic            dir_in, is_ctrl, is_iso, hb;
    logic [1:0]      bk, nbanks, ntrans;
    logic [2:0]      szc;
    logic [BC_W-1:0] bank_size;
    logic            fifo_control, rel_done, release_bank;
    logic            acc, wr, mapped;
    logic            wr_clear, wr_config, wr_mask, wr_ctrl;
    logic [1:0]      head_bank, tail_bank;
    logic            inc_ev, dec_ev;
    logic [1:0]      inc_bank, dec_bank;
    logic            rx_full, out_ok;
    logic            flush, underflow_in, err_any;
    logic [NF-1:0]   flag_set, flag_clr;
    logic [7:0]      disp;
    logic            busy_evt, cfg_fits;
    logic [15:0]     need_bytes;
    logic [1:0]      new_bk;
    logic [2:0]      new_sz;
    logic [1:0]      exp_pid;

    function automatic logic [1:0] wrap(input logic [2:0] v, input logic [1:0] n);
        logic [2:0] d;
        d = v - {1'b0, n};
        return (v >= {1'b0, n}) ? d[1:0] : v[1:0];
    endfunction : wrap

    assign ep_type   = ueps_pkg::ueps_type_t'(cfg_reg[`UEPS_CFG_TY_HI:`UEPS_CFG_TY_LO]);
    assign dir_in    = cfg_reg[`UEPS_CFG_DIR];
    assign is_ctrl   = (ep_type == ueps_pkg::EP_CTRL);
    assign is_iso    = (ep_type == ueps_pkg::EP_ISO);
    assign bk        = cfg_reg[`UEPS_CFG_BK_HI:`UEPS_CFG_BK_LO];
    assign nbanks    = (bk == `UEPS_BK_RSVD) ? bk : bk + 2'h1;
    assign ntrans    = cfg_reg[`UEPS_CFG_NT_HI:`UEPS_CFG_NT_LO];
    assign hb        = is_iso && (ntrans >= 2'h2);
    assign szc       = cfg_reg[`UEPS_CFG_SZ_HI:`UEPS_CFG_SZ_LO];
    assign bank_size = BC_W'(`UEPS_BANK_MIN << szc);

    // APB decode, zero wait states
    assign acc       = psel && penable;
    assign wr        = acc && pwrite;
    assign mapped    = (paddr == `UEPS_OFF_STATUS) || (paddr == `UEPS_OFF_CLEAR) ||
                       (paddr == `UEPS_OFF_CONFIG) || (paddr == `UEPS_OFF_MASK) ||
                       (paddr == `UEPS_OFF_CTRL);
    assign pready    = 1'b1;
    assign pslverr   = acc && !mapped;
    assign prdata    = rdata_reg;
    assign wr_clear  = wr && (paddr == `UEPS_OFF_CLEAR);
    assign wr_config = wr && (paddr == `UEPS_OFF_CONFIG);
    assign wr_mask   = wr && (paddr == `UEPS_OFF_MASK);
    assign wr_ctrl   = wr && (paddr == `UEPS_OFF_CTRL);

    // Bank held by software until release; release waits out the pipe
    assign fifo_control      = !(|rel_pipe_reg) && !is_ctrl &&
                          (dir_in ? (busy_reg < nbanks) : (busy_reg != 2'h0));
    assign release_bank = wr_ctrl && pwdata[`UEPS_CTL_RELEASE] && fifo_control;
    assign rel_done     = rel_pipe_reg[1];

    // Oldest busy bank and next bank the host fills
    assign head_bank = wrap(3'({1'b0, cur_bank_reg}) + 3'({1'b0, nbanks}) -
                            3'({1'b0, busy_reg}), nbanks);
    assign tail_bank = wrap(3'({1'b0, cur_bank_reg}) + 3'({1'b0, busy_reg}), nbanks);

    // bytes beyond the bank are dropped
    assign rx_full  = (bcnt_reg[tail_bank] == bank_size);
    assign inc_ev   = dir_in ? sw_byte_wr : (usb_byte_rx && !drop_reg && !rx_full);
    assign inc_bank = dir_in ? cur_bank_reg : tail_bank;
    assign dec_ev   = dir_in ? usb_byte_tx : sw_byte_rd;
    assign dec_bank = dir_in ? head_bank : cur_bank_reg;
    assign out_ok   = !dir_in && usb_out_done && !drop_reg;

    assign underflow_in = is_iso && dir_in && usb_in_token && (busy_reg == 2'h0);
    assign send_zlp     = underflow_in;
    assign out_discard  = is_iso && !dir_in && usb_out_start && (busy_reg == nbanks);
    assign flush        = usb_microframe_end && hb && dir_in && (mf_tx_reg < ntrans);
    assign fifo_flush   = flush;

    assign err_any      = flag_reg[F_OVER] || flag_reg[F_UNDER] || trerr_reg;
    assign rw_allowed   = fifo_control && !stall_reg && !err_any &&
                          (dir_in ? (bcnt_reg[cur_bank_reg] < bank_size)
                                  : (bcnt_reg[cur_bank_reg] != '0));
    assign stall_request = stall_reg;

    // expected PID order within a microframe
    always_comb begin
        exp_pid = ueps_pkg::PID_DATA0;
        if (ntrans == 2'h3)
            exp_pid = (mf_rx_reg == 2'h2) ? ueps_pkg::PID_DATA2 : ueps_pkg::PID_MDATA;
        else if (ntrans == 2'h2)
            exp_pid = (mf_rx_reg == 2'h1) ? ueps_pkg::PID_DATA1 : ueps_pkg::PID_MDATA;
    end

    always_comb begin
        flag_set          = '0;
        flag_set[F_INRDY] = dir_in && fifo_control && !fifo_control_d_reg;
        flag_set[F_OUTRX] = (!dir_in && fifo_control && !fifo_control_d_reg) ||
                            (is_ctrl && usb_out_done);
        flag_set[F_SETUP] = is_ctrl && usb_setup_rcv;
        flag_set[F_NAKOUT] = usb_nak_out_sent;
        flag_set[F_NAKIN]  = usb_nak_in_sent;
        flag_set[F_OVER]  = !dir_in && usb_byte_rx && !drop_reg && rx_full;
        flag_set[F_STALL] = usb_stall_sent && stall_reg;
        flag_set[F_SHORT] = !is_ctrl && out_ok && (bcnt_reg[tail_bank] < bank_size);
        flag_set[F_UNDER] = underflow_in || out_discard;
        flag_set[F_HBUND] = usb_microframe_end && hb && dir_in && (mf_fill_reg < ntrans);
        flag_set[F_FLUSH] = flush;
        flag_set[F_CRC]   = is_iso && !dir_in && usb_out_crc_err;
    end

    // clear bits are shared by aliased flags
    always_comb begin
        flag_clr = '0;
        if (wr_clear) begin
            flag_clr[7:0]   = pwdata[7:0];
            flag_clr[F_UNDER] = pwdata[F_SETUP];
            flag_clr[F_HBUND] = pwdata[F_NAKOUT];
            flag_clr[F_FLUSH] = pwdata[F_NAKIN];
            flag_clr[F_CRC]   = pwdata[F_STALL];
        end
    end

    // One sticky flag per bit, set wins over clear
    for (genvar i = 0; i < NF; i++) begin : g_flag
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
                flag_reg[i] <= 1'b0;
            else if (flag_set[i])
                flag_reg[i] <= 1'b1;
            else if (flag_clr[i] || usb_bus_reset)
                flag_reg[i] <= 1'b0;
        end
    end

    for (genvar b = 0; b < 3; b++) begin : g_bank
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
                bcnt_reg[b] <= '0;
            else if (usb_bus_reset || flush)
                bcnt_reg[b] <= '0;
            else if (inc_ev && inc_bank == 2'(b) && !(dec_ev && dec_bank == 2'(b)))
                bcnt_reg[b] <= bcnt_reg[b] + BC_W'(1);
            else if (dec_ev && dec_bank == 2'(b) && bcnt_reg[b] != '0 &&
                     !(inc_ev && inc_bank == 2'(b)))
                bcnt_reg[b] <= bcnt_reg[b] - BC_W'(1);
        end
    end

    // busy count lands two cycles after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rel_pipe_reg <= '0;
        else
            rel_pipe_reg <= {rel_pipe_reg[0], release_bank && !usb_bus_reset};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            busy_reg <= '0;
        else if (usb_bus_reset || flush)
            busy_reg <= '0;
        else if (dir_in) begin
            if (rel_done && !(usb_in_done && busy_reg != 2'h0))
                busy_reg <= busy_reg + 2'h1;
            else if (!rel_done && usb_in_done && busy_reg != 2'h0)
                busy_reg <= busy_reg - 2'h1;
        end else begin
            if (out_ok && !rel_done && busy_reg < nbanks)
                busy_reg <= busy_reg + 2'h1;
            else if (rel_done && !out_ok && busy_reg != 2'h0)
                busy_reg <= busy_reg - 2'h1;
        end
    end

    // bank advances after the release pipe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cur_bank_reg <= '0;
        else if (usb_bus_reset || is_ctrl)
            cur_bank_reg <= '0;
        else if (rel_done)
            cur_bank_reg <= wrap(3'({1'b0, cur_bank_reg}) + 3'h1, nbanks);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            drop_reg <= 1'b0;
        else if (out_discard)
            drop_reg <= 1'b1;
        else if (usb_out_done || usb_bus_reset)
            drop_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fifo_control_d_reg <= 1'b0;
        else
            fifo_control_d_reg <= fifo_control;
    end

    // Microframe counters: good IN sends, fills, OUT packets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mf_tx_reg   <= '0;
            mf_fill_reg <= '0;
            mf_rx_reg   <= '0;
        end else if (usb_microframe_end || usb_bus_reset) begin
            mf_tx_reg   <= '0;
            mf_fill_reg <= '0;
            mf_rx_reg   <= '0;
        end else begin
            if (usb_in_done && busy_reg != 2'h0 && mf_tx_reg != 2'h3)
                mf_tx_reg <= mf_tx_reg + 2'h1;
            if (release_bank && dir_in && mf_fill_reg != 2'h3)
                mf_fill_reg <= mf_fill_reg + 2'h1;
            if (out_ok && mf_rx_reg != 2'h3)
                mf_rx_reg <= mf_rx_reg + 2'h1;
        end
    end

    // toggle violation held until a bank release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            trerr_reg <= 1'b0;
        else if (out_ok && hb && (usb_out_pid != exp_pid || mf_rx_reg >= ntrans))
            trerr_reg <= 1'b1;
        else if (rel_done || usb_bus_reset)
            trerr_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            toggle_sequence_reg <= `UEPS_TOGGLE_SEQUENCE_RST;
        else if (usb_bus_reset || (wr_ctrl && pwdata[`UEPS_CTL_RSTDT]))
            toggle_sequence_reg <= `UEPS_TOGGLE_SEQUENCE_RST;
        else if (out_ok)
            toggle_sequence_reg <= usb_out_pid;
        else if (dir_in && usb_in_done) begin
            if (!is_iso)
                toggle_sequence_reg <= {1'b0, ~toggle_sequence_reg[0]};
            else if (hb && (ntrans - mf_tx_reg) == 2'h3)
                toggle_sequence_reg <= ueps_pkg::PID_DATA1;
            else
                toggle_sequence_reg <= ueps_pkg::PID_DATA0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            control_direction_reg <= 1'b0;
        else if (usb_bus_reset)
            control_direction_reg <= 1'b0;
        else if (usb_setup_rcv && is_ctrl)
            control_direction_reg <= usb_setup_dir_in;
    end

    assign new_bk     = pwdata[`UEPS_CFG_BK_HI:`UEPS_CFG_BK_LO];
    assign new_sz     = pwdata[`UEPS_CFG_SZ_HI:`UEPS_CFG_SZ_LO];
    assign need_bytes = 16'({14'h0, new_bk} + 16'h1) * 16'(`UEPS_BANK_MIN << new_sz);
    assign cfg_fits   = (new_bk != `UEPS_BK_RSVD) && (int'(new_bk) < MAX_BANKS) &&
                        (int'(new_sz) <= MAX_SZCODE) && (int'(need_bytes) <= FIFO_BYTES);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg   <= `UEPS_CFG_RST;
            config_valid_reg <= 1'b0;
        end else if (wr_config) begin
            cfg_reg   <= pwdata[`UEPS_CFG_W-1:0];
            config_valid_reg <= pwdata[`UEPS_CFG_MEM_ALLOCATE] && cfg_fits;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mask_reg <= '0;
        else if (wr_mask)
            mask_reg <= pwdata[`UEPS_MSK_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            stall_reg <= 1'b0;
        else if (usb_bus_reset)
            stall_reg <= 1'b0;
        else if (wr_ctrl)
            stall_reg <= pwdata[`UEPS_CTL_STALL];
    end

    // Iso endpoints show the alternate meaning of shared bits
    assign disp = {flag_reg[F_SHORT],
                   is_iso ? flag_reg[F_CRC]   : flag_reg[F_STALL],
                   flag_reg[F_OVER],
                   is_iso ? flag_reg[F_FLUSH] : flag_reg[F_NAKIN],
                   is_iso ? flag_reg[F_HBUND] : flag_reg[F_NAKOUT],
                   is_iso ? flag_reg[F_UNDER] : flag_reg[F_SETUP],
                   flag_reg[F_OUTRX], flag_reg[F_INRDY]};

    // all free on IN, all busy on OUT
    assign busy_evt = !is_ctrl && (dir_in ? (busy_reg == 2'h0) : (busy_reg == nbanks));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= (|(disp & mask_reg[7:0])) ||
                       (mask_reg[`UEPS_MSK_BUSY] && busy_evt) ||
                       (mask_reg[`UEPS_MSK_TRERR] && trerr_reg) ||
                       (mask_reg[`UEPS_MSK_MDATA] && hb && flag_reg[F_OUTRX] &&
                        toggle_sequence_reg == ueps_pkg::PID_MDATA) ||
                       (mask_reg[`UEPS_MSK_DATAX] && hb && flag_reg[F_OUTRX] &&
                        toggle_sequence_reg != ueps_pkg::PID_MDATA);
    end
    assign endpoint_irq = irq_reg;

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rdata_reg <= '0;
        else if (psel && !penable && !pwrite) begin
            rdata_reg <= '0;
            unique case (paddr)
                `UEPS_OFF_STATUS: begin
                    rdata_reg[`UEPS_ST_BC_LO +: BC_W]  <= bcnt_reg[cur_bank_reg];
                    rdata_reg[`UEPS_ST_CONFIG_VALID]          <= config_valid_reg;
                    rdata_reg[`UEPS_ST_CONTROL_DIRECTION]        <= control_direction_reg;
                    rdata_reg[`UEPS_ST_RW_ALLOWED]          <= rw_allowed;
                    rdata_reg[`UEPS_ST_CURBK_LO +: 2]  <= cur_bank_reg;
                    rdata_reg[`UEPS_ST_BUSY_LO +: 2]   <= busy_reg;
                    rdata_reg[`UEPS_ST_TRERR]          <= trerr_reg;
                    rdata_reg[`UEPS_ST_TOGGLE_SEQUENCE_LO +: 2]  <= toggle_sequence_reg;
                    rdata_reg[7:0]                     <= disp;
                end
                `UEPS_OFF_CONFIG: rdata_reg[`UEPS_CFG_W-1:0] <= cfg_reg;
                `UEPS_OFF_MASK:   rdata_reg[`UEPS_MSK_W-1:0] <= mask_reg;
                `UEPS_OFF_CTRL: begin
                    rdata_reg[`UEPS_CTL_STALL]   <= stall_reg;
                    rdata_reg[`UEPS_CTL_FIFO_CONTROL] <= fifo_control;
                end
                default: rdata_reg <= '0;
            endcase
        end
    end
endmodule : ueps_endpoint

`default_nettype wire

/* design/ueps_params.svh */
`ifndef UEPS_PARAMS_SVH
`define UEPS_PARAMS_SVH

// Register byte offsets
`define UEPS_OFF_STATUS  12'h000
`define UEPS_OFF_CLEAR   12'h004
`define UEPS_OFF_CONFIG  12'h008
`define UEPS_OFF_MASK    12'h00c
`define UEPS_OFF_CTRL    12'h010

// Status layout
`define UEPS_ST_BC_LO    20
`define UEPS_ST_CONFIG_VALID    18
`define UEPS_ST_CONTROL_DIRECTION  17
`define UEPS_ST_RW_ALLOWED    16
`define UEPS_ST_CURBK_LO 14
`define UEPS_ST_BUSY_LO  12
`define UEPS_ST_TRERR    10
`define UEPS_ST_TOGGLE_SEQUENCE_LO 8

// Config layout
`define UEPS_CFG_MEM_ALLOCATE   0
`define UEPS_CFG_BK_LO   2
`define UEPS_CFG_BK_HI   3
`define UEPS_CFG_SZ_LO   4
`define UEPS_CFG_SZ_HI   6
`define UEPS_CFG_DIR     8
`define UEPS_CFG_TY_LO   11
`define UEPS_CFG_TY_HI   12
`define UEPS_CFG_NT_LO   13
`define UEPS_CFG_NT_HI   14
`define UEPS_CFG_W       15
`define UEPS_CFG_RST     15'h2000

// Mask layout: bits 7..0 follow the flag bits
`define UEPS_MSK_BUSY    8
`define UEPS_MSK_TRERR   9
`define UEPS_MSK_MDATA   10
`define UEPS_MSK_DATAX   11
`define UEPS_MSK_W       12

// Control layout
`define UEPS_CTL_RELEASE 0
`define UEPS_CTL_STALL   1
`define UEPS_CTL_RSTDT   2
`define UEPS_CTL_FIFO_CONTROL 3

`define UEPS_TOGGLE_SEQUENCE_RST   2'h1
`define UEPS_BANK_MIN    16'h0008
`define UEPS_BK_RSVD     2'h3

`endif

/* design/ueps_pkg.sv */
package ueps_pkg;
    typedef enum logic [1:0] {
        EP_CTRL = 2'h0,
        EP_ISO  = 2'h1,
        EP_BULK = 2'h2,
        EP_INTR = 2'h3
    } ueps_type_t;

    typedef enum logic [1:0] {
        PID_DATA0 = 2'h0,
        PID_DATA1 = 2'h1,
        PID_DATA2 = 2'h2,
        PID_MDATA = 2'h3
    } ueps_pid_t;
endpackage : ueps_pkg

/* verification/ueps_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ueps_host_model (
    input  wire logic  pclk,
    output logic       usb_bus_reset, usb_byte_rx, usb_byte_tx, usb_in_token, usb_in_done,
    output logic       usb_out_start, usb_out_done, usb_out_crc_err, usb_setup_rcv,
    output logic       usb_setup_dir_in, usb_nak_in_sent, usb_nak_out_sent, usb_stall_sent,
    output logic       usb_microframe_end,
    output logic [1:0] usb_out_pid
);
    initial begin
        {usb_bus_reset, usb_byte_rx, usb_byte_tx, usb_in_token, usb_in_done, usb_out_start} = '0;
        {usb_out_done, usb_out_crc_err, usb_setup_rcv, usb_setup_dir_in, usb_nak_in_sent} = '0;
        {usb_nak_out_sent, usb_stall_sent, usb_microframe_end, usb_out_pid} = '0;
    end
    task automatic out_packet(input int n, input logic [1:0] pid);
        @(posedge pclk) usb_out_start <= 1'b1;
        @(posedge pclk) usb_out_start <= 1'b0;
        usb_byte_rx <= 1'b1;
        repeat (n) @(posedge pclk);
        usb_byte_rx <= 1'b0;
        usb_out_done <= 1'b1;
        usb_out_pid <= pid;
        @(posedge pclk) usb_out_done <= 1'b0;
        // Stale PID must not look valid
        usb_out_pid <= ~pid;
    endtask : out_packet
    task automatic in_request();
        @(posedge pclk) usb_in_token <= 1'b1;
        @(posedge pclk) usb_in_token <= 1'b0;
        usb_in_done <= 1'b1;
        @(posedge pclk) usb_in_done <= 1'b0;
    endtask : in_request
    task automatic ev(input int k);
        @(posedge pclk) usb_nak_in_sent <= (k == 0);
        usb_nak_out_sent <= (k == 1);
        usb_stall_sent <= (k == 2);
        usb_microframe_end <= (k == 3);
        usb_setup_rcv <= (k == 4 || k == 5);
        usb_setup_dir_in <= (k == 4);
        usb_out_crc_err <= (k == 6);
        usb_byte_tx <= (k == 7);
        usb_bus_reset <= (k == 8);
        @(posedge pclk);
        {usb_nak_in_sent, usb_nak_out_sent, usb_stall_sent, usb_microframe_end} <= '0;
        {usb_setup_rcv, usb_out_crc_err, usb_byte_tx, usb_bus_reset} <= '0;
    endtask : ev
endmodule : ueps_host_model
`default_nettype wire

/* verification/ueps_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ueps_params.svh"
module ueps_props (
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        usb_bus_reset, usb_in_token, usb_out_start, usb_microframe_end,
    input wire logic        usb_stall_sent, usb_nak_in_sent, stall_request, send_zlp,
    input wire logic        out_discard, fifo_flush, rw_allowed, endpoint_irq
);
    logic [11:0] mask_reg;
    wire logic   acc = psel && penable;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of the interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mask_reg <= 12'h000;
        else if (acc && pwrite && paddr == `UEPS_OFF_MASK) mask_reg <= pwdata[11:0];
    end
    property p_stall_rw; stall_request |-> !rw_allowed; endproperty
    a_stall_rw: assert property (p_stall_rw) else $error("allowed while stalled");
    property p_zlp; send_zlp |-> usb_in_token; endproperty
    a_zlp: assert property (p_zlp) else $error("zlp without token");
    property p_discard; out_discard |-> usb_out_start; endproperty
    a_discard: assert property (p_discard) else $error("discard without packet");
    property p_flush; fifo_flush |-> usb_microframe_end; endproperty
    a_flush: assert property (p_flush) else $error("flush off frame end");
    property p_clr_zero; acc && !pwrite && paddr == `UEPS_OFF_CLEAR |-> prdata == 32'h0; endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("clear reg not zero");
    property p_irq_off; mask_reg == 12'h000 && $past(mask_reg) == 12'h000 |-> !endpoint_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
    property p_stall_irq;
        usb_stall_sent && stall_request && mask_reg[6] && !usb_bus_reset |-> ##[1:3] endpoint_irq;
    endproperty
    a_stall_irq: assert property (p_stall_irq) else $error("no stall irq");
    property p_nak_irq; usb_nak_in_sent && mask_reg[4] && !usb_bus_reset |-> ##[1:3] endpoint_irq;
    endproperty
    a_nak_irq: assert property (p_nak_irq) else $error("no nak irq");
endmodule : ueps_props
bind ueps_endpoint ueps_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .usb_bus_reset, .usb_in_token, .usb_out_start, .usb_microframe_end,
    .usb_stall_sent, .usb_nak_in_sent, .stall_request, .send_zlp, .out_discard, .fifo_flush,
    .rw_allowed, .endpoint_irq);
`default_nettype wire

/* verification/ueps_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ueps_params.svh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sw_byte_wr, sw_byte_rd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, st;
    logic        stall_request, send_zlp, out_discard, fifo_flush, rw_allowed, endpoint_irq, slv_err;
    logic        usb_bus_reset, usb_byte_rx, usb_byte_tx, usb_in_token, usb_in_done;
    logic        usb_out_start, usb_out_done, usb_out_crc_err, usb_setup_rcv, usb_setup_dir_in;
    logic        usb_nak_in_sent, usb_nak_out_sent, usb_stall_sent, usb_microframe_end;
    logic [1:0]  usb_out_pid;
    int          miscompares, n_tests;
    ueps_endpoint i_dut (.*);
    ueps_host_model i_host (.*);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        st = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(st & m, e);
    endtask : rdc
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, sw_byte_wr, sw_byte_rd} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`UEPS_OFF_STATUS, 32'hffff_ffff, 32'h0000_0100);
        rdc(`UEPS_OFF_CLEAR, 32'hffff_ffff, 32'h0);
        chk({31'h0, slv_err}, 32'h0);
        apb(1'b1, `UEPS_OFF_CONFIG, 32'h0000_300d);
        rdc(`UEPS_OFF_STATUS, 32'h0004_0000, 32'h0);
        apb(1'b1, `UEPS_OFF_CONFIG, 32'h0000_3001);
        rdc(`UEPS_OFF_STATUS, 32'h0004_0000, 32'h0004_0000);
        i_host.out_packet(5, ueps_pkg::PID_DATA0);
        repeat (4) @(posedge pclk);
        rdc(`UEPS_OFF_STATUS, 32'hffff_ffff, 32'h0055_1082);
        sw_byte_rd <= 1'b1;
        repeat (2) @(posedge pclk);
        sw_byte_rd <= 1'b0;
        rdc(`UEPS_OFF_STATUS, 32'h7ff0_0000, 32'h0030_0000);
        apb(1'b1, `UEPS_OFF_CLEAR, 32'h0000_00ff);
        apb(1'b1, `UEPS_OFF_CTRL, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        rdc(`UEPS_OFF_STATUS, 32'h0001_30ff, 32'h0);
        i_host.out_packet(10, ueps_pkg::PID_DATA1);
        repeat (4) @(posedge pclk);
        rdc(`UEPS_OFF_STATUS, 32'hffff_ffff, 32'h0084_1122);
        apb(1'b1, `UEPS_OFF_CLEAR, 32'h0000_00ff);
        apb(1'b1, `UEPS_OFF_CTRL, 32'h0000_0001);
        apb(1'b1, `UEPS_OFF_MASK, 32'h0000_0050);
        apb(1'b1, `UEPS_OFF_CTRL, 32'h0000_0002);
        i_host.ev(2);
        repeat (3) @(posedge pclk);
        chk({31'h0, endpoint_irq}, 32'h1);
        apb(1'b1, `UEPS_OFF_CLEAR, 32'h0000_0040);
        rdc(`UEPS_OFF_STATUS, 32'h0000_0040, 32'h0);
        apb(1'b1, `UEPS_OFF_CTRL, 32'h0);
        i_host.ev(0);
        i_host.ev(1);
        repeat (3) @(posedge pclk);
        chk({31'h0, endpoint_irq}, 32'h1);
        rdc(`UEPS_OFF_STATUS, 32'h0000_0018, 32'h0000_0018);
        apb(1'b1, `UEPS_OFF_CLEAR, 32'h0000_0018);
        apb(1'b1, `UEPS_OFF_MASK, 32'h0);
        apb(1'b1, `UEPS_OFF_CONFIG, 32'h0000_2001);
        i_host.ev(4);
        apb(1'b1, `UEPS_OFF_STATUS, 32'h0);
        rdc(`UEPS_OFF_STATUS, 32'h0002_0000, 32'h0002_0000);
        i_host.ev(5);
        rdc(`UEPS_OFF_STATUS, 32'h0002_0000, 32'h0);
        apb(1'b1, `UEPS_OFF_CONFIG, 32'h0000_2901);
        i_host.in_request();
        rdc(`UEPS_OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
        apb(1'b1, `UEPS_OFF_CLEAR, 32'h0000_0004);
        apb(1'b1, `UEPS_OFF_CONFIG, 32'h0000_4905);
        i_host.ev(3);
        repeat (2) @(posedge pclk);
        rdc(`UEPS_OFF_STATUS, 32'h0000_0018, 32'h0000_0018);
        apb(1'b1, `UEPS_OFF_CONFIG, 32'h0000_4805);
        i_host.ev(6);
        i_host.out_packet(1, ueps_pkg::PID_DATA0);
        rdc(`UEPS_OFF_STATUS, 32'h0000_0440, 32'h0000_0440);
        i_host.ev(8);
        rdc(`UEPS_OFF_STATUS, 32'h7ff0_37ff, 32'h0000_0100);
        apb(1'b1, `UEPS_OFF_CONFIG, 32'h0000_3101);
        apb(1'b1, `UEPS_OFF_CLEAR, 32'h0000_0001);
        sw_byte_wr <= 1'b1;
        repeat (3) @(posedge pclk);
        sw_byte_wr <= 1'b0;
        rdc(`UEPS_OFF_STATUS, 32'h7ff0_0001, 32'h0030_0000);
        i_host.ev(7);
        rdc(`UEPS_OFF_STATUS, 32'h7ff0_0000, 32'h0020_0000);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
